// *** verilog/t8oc_timer.sv ***
`timescale 1ns/10ps
module t8oc_timer
  import t8oc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic crystal_pin_a_i,
  input wire logic ovf_irq_ack_i,
  input wire logic cmp_irq_ack_i,
  output logic overflow_irq_o,
  output logic compare_irq_o,
  output logic compare_output_o,
  output logic compare_output_en_o
);

  // ****************************************************************
  // state
  // ****************************************************************
  logic [2:0] clock_select_r;
  t8oc_wgm_type waveform_mode_r;
  logic [1:0] compare_output_mode_r;
  logic async_clock_select_r;
  logic [7:0] count_value_r;
  logic [7:0] cmp_act_r;
  logic [7:0] cmp_buf_r;
  logic overflow_flag_r;
  logic compare_flag_r;
  logic ovf_ie_r;
  logic compare_irq_enable_r;
  logic block_r;
  logic oc_r;
  t8oc_dir_type dir_r;
  logic ack_r;
  logic [7:0] rd_r;
  logic [2:0] xs_r;
  logic xl_r;
  logic xrise_r;

  logic acc;
  logic wr;
  logic wr_ctrl;
  logic wr_cnt;
  logic wr_cmp;
  logic wr_mask;
  logic wr_flag;
  logic wr_async;
  logic tick;
  logic pwm;
  logic match;
  logic at_max;
  logic at_bot;
  logic ovf_evt;
  logic cmp_evt;
  logic force_cmp;
  logic bot_evt;
  logic [7:0] d;
  logic [1:0] com_now;

  t8oc_tick_if tk ();

  // ****************************************************************
  // wishbone slave
  // ****************************************************************
  // one cycle answer; registers update on the edge that raises ack
  assign acc = wb_cyc_i && wb_stb_i && !ack_r;
  assign wr = acc && wb_we_i && wb_sel_i[0];
  assign d = wb_dat_i[7:0];
  assign wr_ctrl = wr && (wb_adr_i == OFS_CTRL);
  assign wr_cnt = wr && (wb_adr_i == OFS_COUNT);
  assign wr_cmp = wr && (wb_adr_i == OFS_COMPARE);
  assign wr_mask = wr && (wb_adr_i == OFS_MASK);
  assign wr_flag = wr && (wb_adr_i == OFS_FLAG);
  assign wr_async = wr && (wb_adr_i == OFS_ASYNC);

  // ack drops the cycle after it was given
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= acc;
    end
  end

  // read data; unmapped addresses answer with zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_r <= RST_BYTE;
    end else if (acc && !wb_we_i) begin
      case (wb_adr_i)
        OFS_CTRL: rd_r <= {1'b0, compare_output_mode_r,
                           waveform_mode_r, clock_select_r};
        OFS_COUNT: rd_r <= count_value_r;
        OFS_COMPARE: rd_r <= pwm ? cmp_buf_r : cmp_act_r;
        OFS_MASK: rd_r <= {6'h00, compare_irq_enable_r, ovf_ie_r};
        OFS_FLAG: rd_r <= {6'h00, compare_flag_r, overflow_flag_r};
        OFS_ASYNC: rd_r <= {4'h0, async_clock_select_r, 3'h0};
        default: rd_r <= RST_BYTE;
      endcase
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = {24'h00_0000, rd_r};

  // ****************************************************************
  // control registers
  // ****************************************************************
  // output mode bits take effect at once, never buffered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clock_select_r <= CS_STOPPED;
      waveform_mode_r <= WGM_NORMAL;
      compare_output_mode_r <= COM_NONE;
    end else if (wr_ctrl) begin
      clock_select_r <= d[CTRL_CS_LSB +: 3];
      waveform_mode_r <= t8oc_wgm_type'(d[CTRL_WGM_LSB +: 2]);
      compare_output_mode_r <= d[CTRL_COM_LSB +: 2];
    end
  end

  // interrupt masks and clock source select
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ovf_ie_r <= 1'b0;
      compare_irq_enable_r <= 1'b0;
      async_clock_select_r <= 1'b0;
    end else begin
      if (wr_mask) begin
        ovf_ie_r <= d[IRQ_OVF_BIT];
        compare_irq_enable_r <= d[IRQ_CMP_BIT];
      end
      if (wr_async) begin
        async_clock_select_r <= d[ASYNC_SEL_BIT];
      end
    end
  end

  // ****************************************************************
  // clock source
  // ****************************************************************
  // crystal pin: three stages, a level counts once stages 2 and 3 agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      xs_r <= 3'h0;
      xl_r <= 1'b0;
      xrise_r <= 1'b0;
    end else begin
      xs_r <= {xs_r[1:0], crystal_pin_a_i};
      xrise_r <= (xs_r[1] == xs_r[2]) && xs_r[2] && !xl_r;
      if (xs_r[1] == xs_r[2]) begin
        xl_r <= xs_r[2];
      end
    end
  end

  // crystal edges replace the io clock as prescaler source
  assign tk.src_en = async_clock_select_r ? xrise_r : 1'b1;
  assign tk.clock_select = clock_select_r;
  assign tick = tk.tick;

  t8oc_presc u_presc (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tk(tk)
  );

  // ****************************************************************
  // counter unit
  // ****************************************************************
  assign pwm = is_pwm(waveform_mode_r);
  assign at_max = (count_value_r == CNT_MAX);
  assign at_bot = (count_value_r == CNT_BOTTOM);
  assign match = (count_value_r == cmp_act_r);

  function automatic logic pwm_phase();
    pwm_phase = (waveform_mode_r == WGM_PHASE);
  endfunction

  // fast pwm and normal wrap at max; counter becomes bottom next
  assign bot_evt = tick && !wr_cnt && at_max && !pwm_phase();

  // cpu write wins over any count or clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_value_r <= CNT_BOTTOM;
    end else if (wr_cnt) begin
      count_value_r <= d;
    end else if (tick) begin
      case (waveform_mode_r)
        WGM_CTC: begin
          // compare value acts as top
          count_value_r <= match ? CNT_BOTTOM :
                           count_value_r + 8'h01;
        end
        WGM_PHASE: begin
          if (dir_r == DIR_UP) begin
            count_value_r <= at_max ? count_value_r - 8'h01 :
                             count_value_r + 8'h01;
          end else begin
            count_value_r <= at_bot ? count_value_r + 8'h01 :
                             count_value_r - 8'h01;
          end
        end
        default: begin
          count_value_r <= count_value_r + 8'h01;
        end
      endcase
    end
  end

  // direction turns at max and bottom in phase correct mode only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dir_r <= DIR_UP;
    end else if (!pwm_phase()) begin
      dir_r <= DIR_UP;
    end else if (tick && !wr_cnt) begin
      if (dir_r == DIR_UP && at_max) begin
        dir_r <= DIR_DOWN;
      end else if (dir_r == DIR_DOWN && at_bot) begin
        dir_r <= DIR_UP;
      end
    end
  end

  // ****************************************************************
  // flags
  // ****************************************************************
  // overflow: at max to bottom, or at the bottom turn in phase mode
  assign ovf_evt = tick && !wr_cnt &&
                   (pwm_phase() ? (dir_r == DIR_DOWN && at_bot) :
                    at_max);
  assign cmp_evt = tick && match && !block_r;

  // a counter write blocks the match of the next tick, even if stopped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      block_r <= 1'b0;
    end else if (wr_cnt) begin
      block_r <= 1'b1;
    end else if (tick) begin
      block_r <= 1'b0;
    end
  end

  // set wins over a clear arriving in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      overflow_flag_r <= 1'b0;
      compare_flag_r <= 1'b0;
    end else begin
      overflow_flag_r <= ovf_evt || (overflow_flag_r &&
        !(ovf_irq_ack_i || (wr_flag && d[IRQ_OVF_BIT])));
      compare_flag_r <= cmp_evt || (compare_flag_r &&
        !(cmp_irq_ack_i || (wr_flag && d[IRQ_CMP_BIT])));
    end
  end

  assign overflow_irq_o = overflow_flag_r && ovf_ie_r;
  assign compare_irq_o = compare_flag_r && compare_irq_enable_r;

  // ****************************************************************
  // compare registers
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmp_buf_r <= RST_BYTE;
    end else if (wr_cmp) begin
      cmp_buf_r <= d;
    end
  end

  // pwm loads the buffer at max only, avoiding odd-length pulses
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmp_act_r <= RST_BYTE;
    end else if (wr_cmp && !pwm) begin
      cmp_act_r <= d;
    end else if (pwm && tick && !wr_cnt && at_max) begin
      cmp_act_r <= cmp_buf_r;
    end
  end

  // ****************************************************************
  // waveform generator
  // ****************************************************************
  assign force_cmp = wr_ctrl && d[CTRL_FORCE_BIT] && !pwm;
  // normal and ctc: com bits written with the strobe act on oc at once, not a cycle late
  assign com_now = wr_ctrl ? d[CTRL_COM_LSB +: 2] :
                   compare_output_mode_r;

  // oc state is never reset by a mode change
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      oc_r <= 1'b0;
    end else begin
      case (waveform_mode_r)
        WGM_FAST: begin
          // bottom wins so a compare at max gives a steady level
          if (bot_evt && compare_output_mode_r[1]) begin
            oc_r <= !compare_output_mode_r[0];
          end else if (cmp_evt && compare_output_mode_r[1]) begin
            oc_r <= compare_output_mode_r[0];
          end
        end
        WGM_PHASE: begin
          if (cmp_evt && compare_output_mode_r[1]) begin
            oc_r <= (dir_r == DIR_UP) ? compare_output_mode_r[0] :
                    !compare_output_mode_r[0];
          end
        end
        default: begin
          if (cmp_evt || force_cmp) begin
            case (com_now)
              COM_TOGGLE: oc_r <= !oc_r;
              COM_CLEAR: oc_r <= 1'b0;
              COM_SET: oc_r <= 1'b1;
              default: oc_r <= oc_r;
            endcase
          end
        end
      endcase
    end
  end

  // pin override only while an output mode is selected
  assign compare_output_o = oc_r;
  assign compare_output_en_o = (compare_output_mode_r != COM_NONE);

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_cnt_wr;
    wr_cnt;
  endsequence

  sequence s_ctc_hit;
    tick && !wr_cnt && waveform_mode_r == WGM_CTC && match;
  endsequence

  stop_no_tick_a: assert property (clock_select_r == CS_STOPPED |-> !tick)
    else $error("tick while clock select is zero");

  cnt_write_a: assert property (s_cnt_wr |=> count_value_r == $past(d))
    else $error("counter write lost");

  wrap_normal_a: assert property (tick && !wr_cnt && at_max &&
    waveform_mode_r == WGM_NORMAL |=> at_bot && overflow_flag_r)
    else $error("normal wrap or overflow wrong");

  ctc_clear_a: assert property (s_ctc_hit |=> at_bot)
    else $error("ctc did not clear counter");

  cmp_flag_a: assert property (tick && match && !block_r
    |=> compare_flag_r)
    else $error("compare flag not set on match tick");

  block_match_a: assert property (tick && match && block_r &&
    !compare_flag_r |=> !compare_flag_r)
    else $error("match not blocked after counter write");

  force_toggle_a: assert property (force_cmp &&
    com_now == COM_TOGGLE && !cmp_evt
    |=> oc_r != $past(oc_r) && $stable(count_value_r))
    else $error("force toggle wrong");

  buf_load_a: assert property (pwm && tick && !wr_cnt && at_max &&
    !wr_ctrl |=> cmp_act_r == $past(cmp_buf_r))
    else $error("buffered compare not loaded at max");

  direct_cmp_a: assert property (wr_cmp && !pwm
    |=> cmp_act_r == $past(d))
    else $error("direct compare write lost");

  fast_bottom_a: assert property (bot_evt && waveform_mode_r == WGM_FAST &&
    compare_output_mode_r == COM_CLEAR && !wr_ctrl |=> oc_r)
    else $error("fast pwm not set at bottom");

endmodule

// *** verilog/t8oc_pkg.sv ***
package t8oc_pkg;

  // ****************************************************************
  // register map, byte addresses on the wishbone bus
  // ****************************************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_COUNT = 8'h04;
  localparam logic [7:0] OFS_COMPARE = 8'h08;
  localparam logic [7:0] OFS_MASK = 8'h0c;
  localparam logic [7:0] OFS_FLAG = 8'h10;
  localparam logic [7:0] OFS_ASYNC = 8'h14;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int CTRL_CS_LSB = 0;
  localparam int CTRL_WGM_LSB = 3;
  localparam int CTRL_COM_LSB = 5;
  localparam int CTRL_FORCE_BIT = 7;
  localparam int ASYNC_SEL_BIT = 3;
  localparam int IRQ_OVF_BIT = 0;
  localparam int IRQ_CMP_BIT = 1;

  // ****************************************************************
  // values and reset values
  // ****************************************************************
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_MAX = 8'hff;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [2:0] CS_STOPPED = 3'h0;
  localparam logic [1:0] COM_NONE = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR = 2'h2;
  localparam logic [1:0] COM_SET = 2'h3;

  // prescaler divide masks: divide by 1, 8, 32, 64, 128, 256, 1024
  localparam logic [9:0] PSC_MASK_1 = 10'h000;
  localparam logic [9:0] PSC_MASK_8 = 10'h007;
  localparam logic [9:0] PSC_MASK_32 = 10'h01f;
  localparam logic [9:0] PSC_MASK_64 = 10'h03f;
  localparam logic [9:0] PSC_MASK_128 = 10'h07f;
  localparam logic [9:0] PSC_MASK_256 = 10'h0ff;
  localparam logic [9:0] PSC_MASK_1024 = 10'h3ff;

  typedef enum logic [1:0] {
    WGM_NORMAL = 2'b00,
    WGM_FAST = 2'b01,
    WGM_CTC = 2'b10,
    WGM_PHASE = 2'b11
  } t8oc_wgm_type;

  typedef enum logic {
    DIR_UP = 1'b0,
    DIR_DOWN = 1'b1
  } t8oc_dir_type;

  // pwm modes double buffer the compare value
  function automatic logic is_pwm(input t8oc_wgm_type m);
    is_pwm = (m == WGM_FAST) || (m == WGM_PHASE);
  endfunction

endpackage

// *** verilog/t8oc_tick_if.sv ***
`timescale 1ns/10ps
interface t8oc_tick_if;
  logic src_en;
  logic [2:0] clock_select;
  logic tick;

  modport ctl (output src_en, output clock_select, input tick);
  modport presc (input src_en, input clock_select, output tick);
endinterface

// *** verilog/t8oc_presc.sv ***
`timescale 1ns/10ps
module t8oc_presc
  import t8oc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  t8oc_tick_if.presc tk
);

  // ****************************************************************
  // prescaler
  // ****************************************************************
  logic [9:0] psc_r;
  logic [9:0] mask;

  // divider mask from the clock select field
  always_comb begin
    case (tk.clock_select)
      3'h1: mask = PSC_MASK_1;
      3'h2: mask = PSC_MASK_8;
      3'h3: mask = PSC_MASK_32;
      3'h4: mask = PSC_MASK_64;
      3'h5: mask = PSC_MASK_128;
      3'h6: mask = PSC_MASK_256;
      default: mask = PSC_MASK_1024;
    endcase
  end

  // held at zero while stopped so a restart gives a full first period
  always_ff @(posedge clk_i) begin
    if (rst_i || tk.clock_select == CS_STOPPED) begin
      psc_r <= 10'h000;
    end else if (tk.src_en) begin
      psc_r <= psc_r + 10'h001;
    end
  end

  // no tick at all without a selected source
  assign tk.tick = tk.src_en && (tk.clock_select != CS_STOPPED) &&
                   ((psc_r & mask) == mask);

endmodule

// *** test/t8oc_xtal_model.sv ***
`timescale 1ns/10ps
// ****************************************************************
// watch crystal stand-in on the first crystal pin
// ****************************************************************
module t8oc_xtal_model (
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [7:0] n_i,
  output logic pin_o,
  output logic busy_o
);
  int i;
  // bursts of n rising edges; pin rests low between bursts so the
  // design sees no stray source pulses
  initial begin
    pin_o = 1'b0;
    busy_o = 1'b0;
    forever begin
      @(posedge clk_i);
      if (go_i === 1'b1) begin
        busy_o <= 1'b1;
        for (i = 0; i < n_i; i++) begin
          repeat (5) @(posedge clk_i);
          pin_o <= 1'b1;
          repeat (5) @(posedge clk_i);
          pin_o <= 1'b0;
        end
        busy_o <= 1'b0;
      end
    end
  end
endmodule

// *** test/testbench.sv ***
`timescale 1ns/10ps
module testbench;
  import t8oc_pkg::*;
  logic clk_i, rst_i, cyc, stb, we, ovf_ack, cmp_ack, go, xpin, xbusy;
  logic [7:0] adr, xn, rd, tmp;
  logic [3:0] sel;
  logic [31:0] dat, dat_o;
  logic ack, ovf_irq, cmp_irq, cout, cout_en;
  int bad_count, n_tests, cycles;
  t8oc_timer i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .crystal_pin_a_i(xpin), .ovf_irq_ack_i(ovf_ack),
    .cmp_irq_ack_i(cmp_ack), .overflow_irq_o(ovf_irq),
    .compare_irq_o(cmp_irq), .compare_output_o(cout),
    .compare_output_en_o(cout_en));
  t8oc_xtal_model i_xtal (.clk_i(clk_i), .go_i(go), .n_i(xn),
    .pin_o(xpin), .busy_o(xbusy));
  // ****************************************************************
  // clock, timeout, verdict
  // ****************************************************************
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // ceiling well above the twelve hundred or so cycles the run needs
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      bad_count = bad_count + 1;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] s);
    n_tests = n_tests + 1;
    if (s !== e) begin
      $display("mismatch %s expected %h seen %h", nm, e, s);
      bad_count = bad_count + 1;
    end
  endtask
  // ****************************************************************
  // wishbone classic master
  // ****************************************************************
  // ack is sampled at the rising edge; read data stands with it,
  // and the request is released only after that edge
  task automatic wb_xfer(input logic w, input logic [7:0] a,
                         input logic [7:0] d);
    int k;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    dat <= {24'h00_0000, d};
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 50);
    rd = dat_o[7:0];
    if (k >= 50) chk("wb_ack", 8'h01, 8'h00);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wb_xfer(1'b1, a, d);
  endtask
  task automatic rchk(input string nm, input logic [7:0] a,
                      input logic [7:0] e);
    wb_xfer(1'b0, a, 8'h00);
    chk(nm, e, rd);
  endtask
  // load counter, run with ctrl for n cycles, stop keeping mode bits
  task automatic run(input logic [7:0] c, input logic [7:0] ctl,
                     input int n);
    wr(OFS_COUNT, c);
    wr(OFS_CTRL, ctl);
    repeat (n) @(posedge clk_i);
    wr(OFS_CTRL, ctl & 8'hf8);
  endtask
  task automatic pulse(input logic which);
    @(posedge clk_i);
    if (which) cmp_ack <= 1'b1;
    else ovf_ack <= 1'b1;
    @(posedge clk_i);
    cmp_ack <= 1'b0;
    ovf_ack <= 1'b0;
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    logic [7:0] ofs[7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10,
                          8'h14, 8'h18};
    wr(8'h18, 8'h5a);
    foreach (ofs[j]) rchk("reset_value", ofs[j], 8'h00);
  endtask
  task automatic t_stopped();
    wr(OFS_COUNT, 8'h5a);
    repeat (20) @(posedge clk_i);
    rchk("stopped_count", OFS_COUNT, 8'h5a);
    wr(OFS_COMPARE, 8'ha5);
    rchk("compare_rw", OFS_COMPARE, 8'ha5);
  endtask
  task automatic t_overflow();
    run(8'hfe, 8'h01, 10);
    rchk("ovf_flag", OFS_FLAG, 8'h01);
    chk("ovf_irq_masked", 8'h00, {7'h00, ovf_irq});
    wr(OFS_MASK, 8'h01);
    chk("ovf_irq", 8'h01, {7'h00, ovf_irq});
    pulse(1'b0);
    rchk("ovf_ack_clear", OFS_FLAG, 8'h00);
    wr(OFS_MASK, 8'h00);
  endtask
  task automatic t_compare();
    wr(OFS_COMPARE, 8'h10);
    run(8'h10, 8'h01, 20);
    rchk("match_blocked", OFS_FLAG, 8'h00);
    run(8'h08, 8'h01, 20);
    rchk("match_flag", OFS_FLAG, 8'h02);
    wr(OFS_MASK, 8'h02);
    chk("cmp_irq", 8'h01, {7'h00, cmp_irq});
    wr(OFS_FLAG, 8'h02);
    rchk("w1c_clear", OFS_FLAG, 8'h00);
    chk("cmp_irq_low", 8'h00, {7'h00, cmp_irq});
    run(8'h08, 8'h01, 20);
    pulse(1'b1);
    rchk("cmp_ack_clear", OFS_FLAG, 8'h00);
    wr(OFS_MASK, 8'h00);
  endtask
  task automatic t_ctc();
    wr(OFS_COMPARE, 8'h08);
    run(8'h00, 8'h11, 100);
    wb_xfer(1'b0, OFS_COUNT, 8'h00);
    chk("ctc_bounded", 8'h01, {7'h00, rd <= 8'h08});
    rchk("ctc_flags", OFS_FLAG, 8'h02);
    wr(OFS_FLAG, 8'h03);
  endtask
  task automatic t_force();
    logic [1:0] com[5] = '{2'h3, 2'h1, 2'h2, 2'h1, 2'h0};
    logic ex[5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
    wb_xfer(1'b0, OFS_COUNT, 8'h00);
    tmp = rd;
    foreach (com[j]) begin
      wr(OFS_CTRL, {1'b1, com[j], 5'h00});
      chk("force_out", {7'h00, ex[j]}, {7'h00, cout});
      chk("out_en", {7'h00, com[j] != 2'h0}, {7'h00, cout_en});
    end
    rchk("force_no_flag", OFS_FLAG, 8'h00);
    rchk("force_no_count", OFS_COUNT, tmp);
  endtask
  task automatic t_pwm();
    wr(OFS_COMPARE, 8'h30);
    wr(OFS_CTRL, 8'h48);
    chk("mode_keeps_out", 8'h01, {7'h00, cout});
    wr(OFS_COMPARE, 8'h80);
    rchk("pwm_buffer_read", OFS_COMPARE, 8'h80);
    run(8'h20, 8'h49, 40);
    chk("pwm_match_clear", 8'h00, {7'h00, cout});
    run(8'hf0, 8'h49, 70);
    chk("pwm_bottom_set", 8'h01, {7'h00, cout});
    rchk("pwm_ovf", OFS_FLAG, 8'h03);
    wr(OFS_FLAG, 8'h03);
  endtask
  task automatic t_async();
    logic [2:0] cs[2] = '{3'h1, 3'h2};
    logic [7:0] np[2] = '{8'd10, 8'd16};
    logic [7:0] ex[2] = '{8'd10, 8'd2};
    int k;
    wr(OFS_CTRL, 8'h00);
    wr(OFS_ASYNC, 8'h08);
    foreach (cs[j]) begin
      wr(OFS_CTRL, 8'h00);
      wr(OFS_CTRL, {5'h00, cs[j]});
      wr(OFS_COUNT, 8'h00);
      @(posedge clk_i);
      xn <= np[j];
      go <= 1'b1;
      @(posedge clk_i);
      go <= 1'b0;
      k = 0;
      do begin
        @(negedge clk_i);
        k++;
      end while (xbusy !== 1'b0 && k < 2000);
      repeat (10) @(posedge clk_i);
      rchk("async_count", OFS_COUNT, ex[j]);
    end
    wr(OFS_CTRL, 8'h00);
    wr(OFS_ASYNC, 8'h00);
  endtask
  // phase pwm: up to max, down through bottom, clear on the up match
  task automatic t_phase();
    wr(OFS_CTRL, 8'h58);
    wr(OFS_COMPARE, 8'h40);
    run(8'hf8, 8'h59, 347);
    rchk("phase_count", OFS_COUNT, 8'h58);
    chk("phase_up_clear", 8'h00, {7'h00, cout});
    rchk("phase_flags", OFS_FLAG, 8'h03);
    wr(OFS_FLAG, 8'h03);
    wr(OFS_CTRL, 8'h00);
  endtask
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    {cyc, stb, we, ovf_ack, cmp_ack, go} = 6'h00;
    adr = 8'h00;
    xn = 8'h00;
    sel = 4'h0;
    dat = 32'h0000_0000;
    bad_count = 0;
    n_tests = 0;
    cycles = 0;
    rst_i = 1'b1;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_stopped();
    t_overflow();
    t_compare();
    t_ctc();
    t_force();
    t_pwm();
    t_async();
    t_phase();
    give_verdict();
  end
endmodule
